/* File: common/dfc_pkg.sv */
// Constants, encodings and carriers shared by the forwarding control files
package dfc_pkg;

    // ==================================================================
    // Register map: printed offsets are indexes, byte address is index*4
    localparam int DFC_AW = 12;
    localparam int DFC_DW = 32;
    localparam logic [7:0] DFC_IDX_PORT_EN = 8'h20;
    localparam logic [7:0] DFC_IDX_MODE = 8'h21;
    localparam logic [7:0] DFC_IDX_STATUS = 8'h22;
    localparam logic [11:0] DFC_ADDR_PORT_EN = {2'h0, DFC_IDX_PORT_EN, 2'h0};
    localparam logic [11:0] DFC_ADDR_MODE = {2'h0, DFC_IDX_MODE, 2'h0};
    localparam logic [11:0] DFC_ADDR_STATUS = {2'h0, DFC_IDX_STATUS, 2'h0};

    // ==================================================================
    // Field positions, reset values and writable masks
    localparam int DFC_BIT_P1_DIS = 5;
    localparam int DFC_BIT_P0_DIS = 4;
    localparam int DFC_BIT_REPL = 7;
    localparam int DFC_BIT_AS_AVAIL = 6;
    localparam int DFC_BIT_SYNC_LO = 2;
    localparam int DFC_BIT_RR = 0;
    localparam int DFC_BIT_SYNCED = 0;
    localparam logic [7:0] DFC_RST_PORT_EN = 8'h30;
    localparam logic [7:0] DFC_RST_MODE = 8'h01;
    localparam logic [7:0] DFC_WMASK_PORT_EN = 8'hF0;
    localparam logic [7:0] DFC_WMASK_MODE = 8'hCF;

    // ==================================================================
    // Bus answers
    localparam logic [1:0] DFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DFC_RESP_SLVERR = 2'h2;

    // ==================================================================
    // Synchronized forwarding mode field
    typedef enum logic [1:0] {
        DFC_SYNC_OFF = 2'h0,
        DFC_SYNC_BASIC = 2'h1,
        DFC_SYNC_INTERLEAVE = 2'h2,
        DFC_SYNC_CONCAT = 2'h3
    } dfc_sync_mode_t;

    // Scheduler states
    typedef enum logic [2:0] {
        DFC_ST_IDLE = 3'h1,
        DFC_ST_SEND = 3'h2,
        DFC_ST_SPARE = 3'h4
    } dfc_state_t;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic [DFC_DW-1:0] data;
        logic long_pkt;
        logic last;
    } dfc_pkt_t;

    typedef struct packed {
        logic rx_port1_forward_disable;
        logic rx_port0_forward_disable;
        logic replicate;
        logic sync_forward_as_available;
        dfc_sync_mode_t output0_sync_forward_mode;
        logic output0_round_robin_forward;
    } dfc_cfg_t;

endpackage

/* File: src/dfc_axil_regs.sv */
// AXI4-Lite register slave holding the forwarding control registers
`timescale 1ns/1ns
module dfc_axil_regs
    import dfc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Write channels
    input wire logic [DFC_AW-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // Read channels
    input wire logic [DFC_AW-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Block side
    input wire logic synced_i,
    output dfc_cfg_t cfg_o
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_held;
        logic w_held;
        logic [DFC_AW-1:0] awaddr;
        logic [7:0] wbyte;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] port_en;
        logic [7:0] mode;
    } dfc_regs_t;

    dfc_regs_t st;
    dfc_regs_t next_st;

    // ==================================================================
    // Channel handling; address and data may arrive in either order
    always_comb
    begin
        next_st = st;
        if (st.bvalid && bready_i)
            next_st.bvalid = 1'b0;
        if (awvalid_i && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = awaddr_i;
        end
        if (wvalid_i && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wbyte = wdata_i[7:0];
            next_st.wlane0 = wstrb_i[0];
        end
        // Only lane 0 carries the 8-bit registers
        if (next_st.aw_held && next_st.w_held && !next_st.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = DFC_RESP_OKAY;
            case (next_st.awaddr)
                DFC_ADDR_PORT_EN:
                    if (next_st.wlane0)
                        next_st.port_en = (st.port_en & ~DFC_WMASK_PORT_EN)
                            | (next_st.wbyte & DFC_WMASK_PORT_EN);
                DFC_ADDR_MODE:
                    if (next_st.wlane0)
                        next_st.mode = (st.mode & ~DFC_WMASK_MODE)
                            | (next_st.wbyte & DFC_WMASK_MODE);
                DFC_ADDR_STATUS:
                    next_st.bresp = DFC_RESP_OKAY;
                default:
                    next_st.bresp = DFC_RESP_SLVERR;
            endcase
        end
        next_st.awready = !next_st.aw_held;
        next_st.wready = !next_st.w_held;
        // Read: one outstanding, answer one cycle after the address
        if (st.rvalid && rready_i)
            next_st.rvalid = 1'b0;
        if (arvalid_i && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = DFC_RESP_OKAY;
            case (araddr_i)
                DFC_ADDR_PORT_EN: next_st.rdata = {24'h000000, st.port_en};
                DFC_ADDR_MODE: next_st.rdata = {24'h000000, st.mode};
                DFC_ADDR_STATUS: next_st.rdata = {31'h00000000, synced_i};
                default:
                begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = DFC_RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.port_en <= DFC_RST_PORT_EN;
            st.mode <= DFC_RST_MODE;
        end
        else
            st <= next_st;
    end

    // ==================================================================
    // Outputs straight from the state flops
    assign awready_o = st.awready;
    assign wready_o = st.wready;
    assign bvalid_o = st.bvalid;
    assign bresp_o = st.bresp;
    assign arready_o = st.arready;
    assign rvalid_o = st.rvalid;
    assign rdata_o = st.rdata;
    assign rresp_o = st.rresp;
    assign cfg_o.rx_port1_forward_disable = st.port_en[DFC_BIT_P1_DIS];
    assign cfg_o.rx_port0_forward_disable = st.port_en[DFC_BIT_P0_DIS];
    assign cfg_o.replicate = st.mode[DFC_BIT_REPL];
    assign cfg_o.sync_forward_as_available = st.mode[DFC_BIT_AS_AVAIL];
    assign cfg_o.output0_sync_forward_mode =
        dfc_sync_mode_t'(st.mode[DFC_BIT_SYNC_LO+1:DFC_BIT_SYNC_LO]);
    assign cfg_o.output0_round_robin_forward = st.mode[DFC_BIT_RR];

endmodule

/* File: src/dfc_forward_ctl.sv */
// Forwarding scheduler: two receive ports into one output, optional replica
// How it works
// - Receive port 1 is not forwarded while its disable bit is set; resets set.
// - Receive port 0 is not forwarded while its disable bit is set; resets set.
// - Replicate bit copies output 0 onto output 1; resets clear.
// - Synchronized mode waits for a line from every enabled port before sending.
// - As-available sends each long line as soon as it is there.
// - As-available has no effect in line concatenation mode.
// - Short sync packets always stay synchronized, whatever as-available says.
// - Mode field: off, basic, interleaved, concatenated; resets to off.
// - Round robin bit (reset set) disables any synchronization.
// - Round robin alternates between ports that are both ready.
// - Synchronized status reads zero from one cycle after synchronized forwarding goes off.
`timescale 1ns/1ns
module dfc_forward_ctl
    import dfc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // AXI4-Lite register port
    input wire logic [DFC_AW-1:0] s_axil_awaddr_i,
    input wire logic s_axil_awvalid_i,
    output logic s_axil_awready_o,
    input wire logic [31:0] s_axil_wdata_i,
    input wire logic [3:0] s_axil_wstrb_i,
    input wire logic s_axil_wvalid_i,
    output logic s_axil_wready_o,
    output logic [1:0] s_axil_bresp_o,
    output logic s_axil_bvalid_o,
    input wire logic s_axil_bready_i,
    input wire logic [DFC_AW-1:0] s_axil_araddr_i,
    input wire logic s_axil_arvalid_i,
    output logic s_axil_arready_o,
    output logic [31:0] s_axil_rdata_o,
    output logic [1:0] s_axil_rresp_o,
    output logic s_axil_rvalid_o,
    input wire logic s_axil_rready_i,
    // Receive port streams
    input wire logic [1:0] rx_valid_i,
    input dfc_pkt_t [1:0] rx_pkt_i,
    output logic [1:0] rx_ready_o,
    // Output port 0
    output logic tx0_valid_o,
    output dfc_pkt_t tx0_pkt_o,
    input wire logic tx0_ready_i,
    // Output port 1 (replica)
    output logic tx1_valid_o,
    output dfc_pkt_t tx1_pkt_o,
    input wire logic tx1_ready_i
);

    // Whole scheduler state
    typedef struct packed {
        dfc_state_t fsm;
        logic grant;
        logic drop;
        logic rr_last;
        logic [1:0] pending;
        logic [1:0] round_mask;
        logic [1:0] rdy;
        logic o0v;
        logic o1v;
        dfc_pkt_t opkt;
        logic synced;
    } dfc_fwd_t;

    dfc_fwd_t st;
    dfc_fwd_t next_st;

    // Decoded configuration
    dfc_cfg_t cfg;
    logic [1:0] en;
    logic [1:0] elig;
    logic [1:0] elig_long;
    logic sync_on;
    logic concat;
    logic as_avail;
    logic all_ready;
    logic same_kind;
    logic take;

    // ==================================================================
    // Register slave
    dfc_axil_regs u_regs (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .awaddr_i(s_axil_awaddr_i),
        .awvalid_i(s_axil_awvalid_i),
        .awready_o(s_axil_awready_o),
        .wdata_i(s_axil_wdata_i),
        .wstrb_i(s_axil_wstrb_i),
        .wvalid_i(s_axil_wvalid_i),
        .wready_o(s_axil_wready_o),
        .bresp_o(s_axil_bresp_o),
        .bvalid_o(s_axil_bvalid_o),
        .bready_i(s_axil_bready_i),
        .araddr_i(s_axil_araddr_i),
        .arvalid_i(s_axil_arvalid_i),
        .arready_o(s_axil_arready_o),
        .rdata_o(s_axil_rdata_o),
        .rresp_o(s_axil_rresp_o),
        .rvalid_o(s_axil_rvalid_o),
        .rready_i(s_axil_rready_i),
        .synced_i(st.synced),
        .cfg_o(cfg)
    );

    // ==================================================================
    // Mode decode; round robin wins if software sets both
    // Concatenation overrides as-available
    assign en = {!cfg.rx_port1_forward_disable, !cfg.rx_port0_forward_disable};
    assign sync_on = !cfg.output0_round_robin_forward
        && (cfg.output0_sync_forward_mode != DFC_SYNC_OFF);
    assign concat = sync_on && (cfg.output0_sync_forward_mode == DFC_SYNC_CONCAT);
    assign as_avail = sync_on && cfg.sync_forward_as_available && !concat;

    // Per-port head qualification
    // Disabled ports are never eligible
    for (genvar p = 0; p < 2; p++)
    begin : g_head
        assign elig[p] = en[p] && rx_valid_i[p];
        assign elig_long[p] = elig[p] && rx_pkt_i[p].long_pkt;
    end

    // Every enabled port has a head, and all heads are of one kind
    assign all_ready = (en != 2'h0) && ((~en | rx_valid_i) == 2'h3);
    assign same_kind = !(en == 2'h3 && rx_pkt_i[0].long_pkt != rx_pkt_i[1].long_pkt);
    assign take = (st.fsm == DFC_ST_SEND) && st.rdy[st.grant] && rx_valid_i[st.grant];

    // Rotating pick: the port not served last goes first
    // Two ports only; more would need a rotator
    function automatic logic pick(input logic [1:0] cand, input logic last_served);
        logic res;
        res = last_served;
        if (cand[!last_served])
            res = !last_served;
        return res;
    endfunction

    // ==================================================================
    // Scheduler; the output slot holds one item until both copies drain
    always_comb
    begin
        next_st = st;

        // Copies drain on their own ready
        if (tx0_ready_i)
            next_st.o0v = 1'b0;
        if (tx1_ready_i)
            next_st.o1v = 1'b0;

        // Leaving sync mode abandons a half-built round
        if (!sync_on)
        begin
            next_st.synced = 1'b0;
            if (st.fsm == DFC_ST_IDLE)
                next_st.pending = 2'h0;
        end

        // Grant is kept for the whole packet
        case (st.fsm)
            DFC_ST_IDLE:
            begin
                next_st.drop = 1'b0;

                if (!sync_on)
                begin
                    // Free running: no attempt to line up the ports
                    if (elig != 2'h0)
                    begin
                        next_st.grant = pick(elig, st.rr_last);
                        next_st.fsm = DFC_ST_SEND;
                    end
                end
                else if (st.pending != 2'h0)
                begin
                    // Inside a round: lowest pending port first
                    next_st.grant = !st.pending[0];
                    if (!en[next_st.grant])
                        next_st.pending[next_st.grant] = 1'b0;
                    else if (rx_valid_i[next_st.grant])
                    begin
                        next_st.fsm = DFC_ST_SEND;
                        // Merged frame keeps only the first port's short packets
                        next_st.drop = concat && !rx_pkt_i[next_st.grant].long_pkt
                            && (st.pending != st.round_mask);
                    end
                end
                else if (as_avail && elig_long != 2'h0)
                begin
                    next_st.grant = pick(elig_long, st.rr_last);
                    next_st.fsm = DFC_ST_SEND;
                end
                else if (all_ready && same_kind
                    && !(as_avail && rx_pkt_i[!en[0]].long_pkt))
                begin
                    next_st.pending = en;
                    next_st.round_mask = en;
                end
            end
            DFC_ST_SEND:
            begin
                // Dropped beats skip the slot
                if (take)
                begin
                    if (!st.drop)
                    begin
                        next_st.opkt = rx_pkt_i[st.grant];
                        // Concatenated line ends only with the last port of the round
                        if (concat && rx_pkt_i[st.grant].long_pkt
                            && (st.pending & ~(2'h1 << st.grant)) != 2'h0)
                            next_st.opkt.last = 1'b0;
                        next_st.o0v = 1'b1;
                        next_st.o1v = cfg.replicate;
                    end

                    if (rx_pkt_i[st.grant].last)
                    begin
                        next_st.fsm = DFC_ST_IDLE;
                        next_st.rr_last = st.grant;
                        next_st.pending[st.grant] = 1'b0;
                        if (sync_on && st.pending != 2'h0
                            && (st.pending & ~(2'h1 << st.grant)) == 2'h0)
                            next_st.synced = 1'b1;
                    end
                end
            end
            default:
                next_st.fsm = DFC_ST_IDLE;
        endcase

        // Status falls as soon as no round can finish
        if (en == 2'h0 || !sync_on)
            next_st.synced = 1'b0;

        // Ready is offered only when the slot will be empty (or the item is dropped)
        next_st.rdy = 2'h0;
        if (next_st.fsm == DFC_ST_SEND
            && (next_st.drop || (!next_st.o0v && !next_st.o1v)))
            next_st.rdy[next_st.grant] = 1'b1;
    end

    // Port 0 goes first after reset
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
            st.fsm <= DFC_ST_IDLE;
            st.rr_last <= 1'b1;
        end
        else
            st <= next_st;
    end

    // ==================================================================
    // Outputs; both ports share one data flop so the copy is exact
    assign rx_ready_o = st.rdy;
    assign tx0_valid_o = st.o0v;
    assign tx0_pkt_o = st.opkt;
    assign tx1_valid_o = st.o1v;
    assign tx1_pkt_o = st.opkt;

    // ==================================================================
    // Checks
    // All sample on the rising edge, off in reset
    a_port1_disabled_block: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && next_st.fsm == DFC_ST_SEND && next_st.grant)
        |-> !cfg.rx_port1_forward_disable)
        else $error("disabled port 1 was granted");

    a_port0_disabled_block: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && next_st.fsm == DFC_ST_SEND && !next_st.grant)
        |-> !cfg.rx_port0_forward_disable)
        else $error("disabled port 0 was granted");

    a_replica_follows: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (take && !st.drop && cfg.replicate) |=> (tx0_valid_o && tx1_valid_o))
        else $error("replica output missed an item");

    a_sync_waits_all: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && sync_on && !as_avail && st.pending == 2'h0)
        |=> (st.fsm == DFC_ST_IDLE) && ($past(all_ready) || st.pending == 2'h0))
        else $error("synchronized line started before all ports were ready");

    a_as_avail_goes: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && as_avail && st.pending == 2'h0 && elig_long != 2'h0)
        |=> st.fsm == DFC_ST_SEND ##1 st.rdy != 2'h0 || tx0_valid_o)
        else $error("as-available line was held back");

    a_concat_no_direct: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && concat && st.pending == 2'h0) |=> st.fsm == DFC_ST_IDLE)
        else $error("concatenation started a line outside a round");

    a_short_stays_sync: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && sync_on && st.pending == 2'h0
        && next_st.fsm == DFC_ST_SEND) |-> rx_pkt_i[next_st.grant].long_pkt)
        else $error("short packet sent outside a synchronized round");

    a_rr_alternates: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && !sync_on && elig == 2'h3)
        |=> st.fsm == DFC_ST_SEND && st.grant != $past(st.rr_last))
        else $error("round robin served the same port twice");

    a_sync_status_off: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !sync_on [*2] |-> !st.synced)
        else $error("sync status set while synchronized forwarding is off");

    a_all_disabled_idle: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st.fsm == DFC_ST_IDLE && en == 2'h0) |=> st.fsm == DFC_ST_IDLE)
        else $error("packet forwarded with both ports disabled");

    a_tx0_holds: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        tx0_valid_o && !tx0_ready_i |=> tx0_valid_o && $stable(tx0_pkt_o))
        else $error("output 0 item changed before taken");

    a_replica_off: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        take && !st.drop && !cfg.replicate |=> !tx1_valid_o)
        else $error("replica output with replicate off");

    a_idle_no_ready: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        st.fsm == DFC_ST_IDLE |-> rx_ready_o == 2'h0)
        else $error("receive ready raised in IDLE");

endmodule

/* File: bench/dfc_sink_model.sv */
// Downstream processor model taking both output streams
`timescale 1ns/1ns
module dfc_sink_model
    import dfc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Stall control
    input wire logic slow_i,
    // Output streams of the block
    input wire logic tx0_valid_i,
    input dfc_pkt_t tx0_pkt_i,
    output logic tx0_ready_o,
    input wire logic tx1_valid_i,
    input dfc_pkt_t tx1_pkt_i,
    output logic tx1_ready_o,
    // Observed traffic
    output int n0_o,
    output int n1_o,
    output dfc_pkt_t p0_o,
    output dfc_pkt_t p1_o
);
    logic tog;
    // One receiver behind both ports, so the replica stalls with the main one
    assign tx0_ready_o = !slow_i || tog;
    assign tx1_ready_o = tx0_ready_o;
    // Count and keep taken beats; a one or two lane receiver is assumed
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tog <= 1'b0;
            n0_o <= 0;
            n1_o <= 0;
            p0_o <= '0;
            p1_o <= '0;
        end
        else
        begin
            tog <= !tog;
            if (tx0_valid_i && tx0_ready_o)
            begin
                n0_o <= n0_o + 1;
                p0_o <= tx0_pkt_i;
            end
            if (tx1_valid_i && tx1_ready_o)
            begin
                n1_o <= n1_o + 1;
                p1_o <= tx1_pkt_i;
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the forwarding control block
`timescale 1ns/1ns
module testbench;
    import dfc_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tx0_valid, tx1_valid, tx0_rdy, tx1_rdy;
    logic [1:0] bresp, rresp, rx_ready;
    logic [31:0] rdata;
    logic [1:0] rx_valid = 2'b00;
    logic [1:0] rep = 2'b00;
    logic [1:0] lg = 2'b11;
    logic slow = 1'b0;
    dfc_pkt_t [1:0] rx_pkt;
    dfc_pkt_t tx0_pkt, tx1_pkt, p0, p1;
    int n0, n1, num_errors = 0, num_checks = 0, cycles = 0;

    // Single-beat packets tagged with their port number
    assign rx_pkt[0] = {32'h0000_00A0, lg[0], 1'b1};
    assign rx_pkt[1] = {32'h0000_00A1, lg[1], 1'b1};
    always #50 clk_i = ~clk_i;

    dfc_forward_ctl uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
        .s_axil_wdata_i(wdata), .s_axil_wstrb_i(4'hF), .s_axil_wvalid_i(wvalid),
        .s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
        .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
        .s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
        .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready), .rx_valid_i(rx_valid),
        .rx_pkt_i(rx_pkt), .rx_ready_o(rx_ready), .tx0_valid_o(tx0_valid),
        .tx0_pkt_o(tx0_pkt), .tx0_ready_i(tx0_rdy), .tx1_valid_o(tx1_valid),
        .tx1_pkt_o(tx1_pkt), .tx1_ready_i(tx1_rdy));
    dfc_sink_model sink (.clk_i(clk_i), .arst_n_i(arst_n_i), .slow_i(slow),
        .tx0_valid_i(tx0_valid), .tx0_pkt_i(tx0_pkt), .tx0_ready_o(tx0_rdy),
        .tx1_valid_i(tx1_valid), .tx1_pkt_i(tx1_pkt), .tx1_ready_o(tx1_rdy),
        .n0_o(n0), .n1_o(n1), .p0_o(p0), .p1_o(p1));

    // A source drops valid once its beat is taken unless told to repeat
    always @(posedge clk_i)
        for (int p = 0; p < 2; p++)
            if (rx_valid[p] && rx_ready[p] && !rep[p])
                rx_valid[p] <= 1'b0;

    // Hang guard: ceiling far above the expected run of under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", 32'(DFC_RESP_OKAY), 32'(bresp));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("rdata", e, rdata);
        chk("rresp", 32'(r), 32'(rresp));
    endtask

    // Reset values, writable mask and an unmapped read
    task automatic t_reset();
        rd(DFC_ADDR_PORT_EN, 32'h30, DFC_RESP_OKAY);
        rd(DFC_ADDR_MODE, 32'h01, DFC_RESP_OKAY);
        rd(DFC_ADDR_STATUS, 32'h0, DFC_RESP_OKAY);
        rd(12'h08C, 32'h0, DFC_RESP_SLVERR);
        wr(DFC_ADDR_PORT_EN, 8'hFF);
        rd(DFC_ADDR_PORT_EN, 32'hF0, DFC_RESP_OKAY);
        wr(DFC_ADDR_PORT_EN, 8'h30);
    endtask

    // Both ports offer without pause: nothing until port 0 is enabled
    task automatic t_disabled();
        int b;
        b = n0;
        rep <= 2'b11;
        rx_valid <= 2'b11;
        idle(40);
        chk("beats off", 32'h0, 32'(n0 - b));
        wr(DFC_ADDR_PORT_EN, 8'h20);
        idle(40);
        chk("port0 on", 32'h1, 32'(n0 > b));
        chk("only port0", 32'hA0, p0.data);
    endtask

    // Both busy behind a stalling receiver: grants must alternate
    task automatic t_rr();
        int b;
        logic prev;
        wr(DFC_ADDR_PORT_EN, 8'h00);
        slow <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            b = n0;
            while (n0 == b) @(posedge clk_i);
            if (i > 0) chk("rr turn", 32'(!prev), 32'(p0.data[0]));
            prev = p0.data[0];
        end
        rep <= 2'b00;
        slow <= 1'b0;
        idle(20);
    endtask

    // Two packets with the replica on: both outputs see identical traffic
    task automatic t_repl();
        int b0;
        int b1;
        wr(DFC_ADDR_MODE, 8'h81);
        b0 = n0;
        b1 = n1;
        rx_valid <= 2'b11;
        idle(20);
        chk("tx0 beats", 32'h2, 32'(n0 - b0));
        chk("tx1 beats", 32'h2, 32'(n1 - b1));
        chk("tx1 data", p0.data, p1.data);
    endtask

    // Port 0 offers alone, then port 1 joins; beats counted on output 0
    task automatic sync_case(input logic [7:0] m, input logic [1:0] k, input int alone);
        int b;
        wr(DFC_ADDR_MODE, m);
        b = n0;
        lg <= k;
        rx_valid <= 2'b01;
        idle(30);
        chk("beats alone", 32'(alone), 32'(n0 - b));
        rx_valid[1] <= 1'b1;
        idle(30);
        chk("beats round", 32'h2, 32'(n0 - b));
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_disabled();
        t_rr();
        t_repl();
        sync_case(8'h04, 2'b11, 0);
        rd(DFC_ADDR_STATUS, 32'h1, DFC_RESP_OKAY);
        sync_case(8'h08, 2'b11, 0);
        sync_case(8'h0C, 2'b11, 0);
        sync_case(8'h44, 2'b11, 1);
        sync_case(8'h4C, 2'b11, 0);
        sync_case(8'h44, 2'b00, 0);
        wr(DFC_ADDR_MODE, 8'h01);
        rd(DFC_ADDR_STATUS, 32'h0, DFC_RESP_OKAY);
        final_report();
    end
endmodule
